// File: bat_imp_defs.vh
// Register map, field positions and timing constants for the impedance sequencer
`ifndef BAT_IMP_DEFS_VH
`define BAT_IMP_DEFS_VH

`define ADDR_TIMING 8'h0D
`define ADDR_CONFIG 8'h0E
`define ADDR_LB_RESULT 8'h0F
`define ADDR_OC_RESULT 8'h10
`define ADDR_LC_RESULT 8'h11

`define TIMING_RESET 8'h00
`define CONFIG_RESET 8'h00
`define RESULT_RESET 8'h00

`define LB_TIMING_HI 5
`define LB_TIMING_LO 4
`define OC_TIMING_HI 3
`define OC_TIMING_LO 2
`define LC_TIMING_HI 1
`define LC_TIMING_LO 0

`define CFG_ACTIVE_BIT 7
`define CFG_ABORT_BIT 6
`define CFG_DLY2SKIP_BIT 3
`define CFG_CUR_HI 2
`define CFG_CUR_LO 0

`define TM_SKIP 2'h0
`define TM_SHORT 2'h1
`define TM_LONG 2'h2

`define CUR_RESERVED 3'h7
`define CUR_OFF 3'h0

`define SHORT_DELAY_MS 10
`define LONG_DELAY_MS 100
`define CLK_KHZ 200000

`define STEP_LB 2'h0
`define STEP_OC 2'h1
`define STEP_LC 2'h2
`define STEP_DONE 2'h3

`endif

// File: battery_impedance_measurement.v
// Battery impedance measurement sequencer with its register file
//
// Notes on behaviour
// - Writing one to active bit starts run, unless the same write also sets the abort bit
// - Start write during a run does not restart it; its current code still takes effect
// - Active bit reads one until run completes or is aborted
// - Loaded-battery timing: skip, 10ms, or 100ms
// - Open-cell timing: skip, 10ms, or 100ms
// - Loaded-cell timing: skip, short, or long
// - Current code selects source level; 111 reserved
// - Loaded-battery result 8-bit, zero when skipped
// - Open-cell result 8-bit, zero when skipped
`timescale 1ns/1ps
`include "bat_imp_defs.vh"

module battery_impedance_measurement #(
  parameter integer SHORT_CYCLES = `SHORT_DELAY_MS * `CLK_KHZ,
  parameter integer LONG_CYCLES = `LONG_DELAY_MS * `CLK_KHZ,
  parameter integer CNT_W = 25
) (
  input wire CLK,                  // 200 MHz clock
  input wire SRST,                 // Synchronous reset, active high
  input wire REG_WR,               // Register write strobe
  input wire REG_RD,               // Register read strobe
  input wire [7:0] REG_ADDR,       // Register address
  input wire [7:0] REG_WDATA,      // Write data
  output reg [7:0] REG_RDATA,      // Read data, valid cycle after REG_RD
  output reg [2:0] TEST_CURRENT,   // Current source code, 0 when idle
  output reg SAMPLE_REQ,           // One-cycle request to the converter
  output reg [1:0] SAMPLE_SEL,     // Which sample is requested
  output reg MEAS_ACTIVE,          // Run in progress
  input wire SAMPLE_DONE,          // Converter result valid, same clock
  input wire [7:0] SAMPLE_DATA     // Converter result
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PICK = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_CONV = 2'h3;

  reg [1:0] state_q;
  reg [1:0] step_q;
  reg [CNT_W-1:0] cnt_q;
  reg [7:0] timing_q;
  reg [3:0] cfg_q;
  wire [7:0] lb_value;
  wire [7:0] oc_value;
  wire [7:0] lc_value;
  reg [1:0] step_tm;
  reg [7:0] rdata_d;
  reg [2:0] cur_d;

  wire wr_cfg = REG_WR && (REG_ADDR == `ADDR_CONFIG);
  wire start = wr_cfg && REG_WDATA[`CFG_ACTIVE_BIT];
  wire abort = wr_cfg && REG_WDATA[`CFG_ABORT_BIT];
  wire [2:0] cur_sel = cfg_q[`CFG_CUR_HI:`CFG_CUR_LO];
  // Abort wins over both clear and load, so results stay as they were
  wire skip_clr = (state_q == ST_PICK) && !abort && (step_q != `STEP_DONE) &&
    (step_tm != `TM_SHORT) && (step_tm != `TM_LONG);
  wire load_now = (state_q == ST_CONV) && !abort && SAMPLE_DONE;

  // Starting write carries its own code; afterwards the stored field rules
  always @* begin
    if (state_q == ST_IDLE)
      cur_d = REG_WDATA[`CFG_CUR_HI:`CFG_CUR_LO];
    else
      cur_d = cur_sel;
    // Reserved code must never reach the source
    if (cur_d == `CUR_RESERVED)
      cur_d = `CUR_OFF;
  end

  always @* begin
    case (step_q)
      `STEP_LB: step_tm = timing_q[`LB_TIMING_HI:`LB_TIMING_LO];
      `STEP_OC: step_tm = timing_q[`OC_TIMING_HI:`OC_TIMING_LO];
      `STEP_LC: step_tm = timing_q[`LC_TIMING_HI:`LC_TIMING_LO];
      default: step_tm = `TM_SKIP;
    endcase
  end

  always @* begin
    case (REG_ADDR)
      `ADDR_TIMING: rdata_d = timing_q;
      `ADDR_CONFIG: rdata_d = {MEAS_ACTIVE, 3'h0, cfg_q};
      `ADDR_LB_RESULT: rdata_d = lb_value;
      `ADDR_OC_RESULT: rdata_d = oc_value;
      `ADDR_LC_RESULT: rdata_d = lc_value;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
      timing_q <= `TIMING_RESET;
      cfg_q <= 4'h0;
    end else begin
      if (REG_RD)
        REG_RDATA <= rdata_d;
      if (REG_WR && REG_ADDR == `ADDR_TIMING)
        timing_q <= {2'h0, REG_WDATA[5:0]};
      if (wr_cfg)
        cfg_q <= REG_WDATA[`CFG_DLY2SKIP_BIT:0];
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      step_q <= `STEP_LB;
      cnt_q <= {CNT_W{1'b0}};
      MEAS_ACTIVE <= 1'b0;
      TEST_CURRENT <= `CUR_OFF;
      SAMPLE_REQ <= 1'b0;
      SAMPLE_SEL <= `STEP_LB;
    end else begin
      SAMPLE_REQ <= 1'b0;
      // Current code may change mid-run; reserved code keeps the source off
      if (MEAS_ACTIVE)
        TEST_CURRENT <= cur_d;
      if (abort) begin
        state_q <= ST_IDLE;
        MEAS_ACTIVE <= 1'b0;
        TEST_CURRENT <= `CUR_OFF;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              state_q <= ST_PICK;
              step_q <= `STEP_LB;
              MEAS_ACTIVE <= 1'b1;
              TEST_CURRENT <= cur_d;
            end
          end
          ST_PICK: begin
            if (step_q == `STEP_DONE) begin
              state_q <= ST_IDLE;
              MEAS_ACTIVE <= 1'b0;
              TEST_CURRENT <= `CUR_OFF;
            end else if (step_tm == `TM_SHORT || step_tm == `TM_LONG) begin
              state_q <= ST_WAIT;
              cnt_q <= (step_tm == `TM_SHORT) ? SHORT_CYCLES[CNT_W-1:0] - 1'b1 :
                LONG_CYCLES[CNT_W-1:0] - 1'b1;
            end else begin
              // Skipped or unused code: the slot clears on skip_clr
              step_q <= step_q + 2'h1;
            end
          end
          ST_WAIT: begin
            if (cnt_q == {CNT_W{1'b0}}) begin
              state_q <= ST_CONV;
              SAMPLE_REQ <= 1'b1;
              SAMPLE_SEL <= step_q;
            end else
              cnt_q <= cnt_q - 1'b1;
          end
          ST_CONV: begin
            // No timeout: a silent converter holds the run until abort
            if (SAMPLE_DONE) begin
              step_q <= step_q + 2'h1;
              state_q <= ST_PICK;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      // Start while busy falls through untouched above
    end
  end

  result_slot #(.STEP(`STEP_LB)) i_result_slot_lb (
    .clk(CLK),
    .srst(SRST),
    .clr(skip_clr),
    .load(load_now),
    .step(step_q),
    .data(SAMPLE_DATA),
    .value(lb_value)
  );

  result_slot #(.STEP(`STEP_OC)) i_result_slot_oc (
    .clk(CLK),
    .srst(SRST),
    .clr(skip_clr),
    .load(load_now),
    .step(step_q),
    .data(SAMPLE_DATA),
    .value(oc_value)
  );

  result_slot #(.STEP(`STEP_LC)) i_result_slot_lc (
    .clk(CLK),
    .srst(SRST),
    .clr(skip_clr),
    .load(load_now),
    .step(step_q),
    .data(SAMPLE_DATA),
    .value(lc_value)
  );

endmodule

// One result register: zeroed when its step is skipped, loaded on conversion
module result_slot #(
  parameter [1:0] STEP = `STEP_LB
) (
  input wire clk,          // Sequencer clock
  input wire srst,         // Synchronous reset, active high
  input wire clr,          // Current step skipped
  input wire load,         // Conversion result arrives
  input wire [1:0] step,   // Step now being worked on
  input wire [7:0] data,   // Converter result
  output reg [7:0] value   // Stored result
);

  always @(posedge clk) begin
    if (srst)
      value <= `RESULT_RESET;
    else if (step == STEP) begin
      if (clr)
        value <= `RESULT_RESET;
      else if (load)
        value <= data;
    end
  end

endmodule

// File: bim_sva.sv
// Port assertions for the impedance sequencer
`timescale 1ns/1ps
module bim_sva (input wire CLK, SRST, REG_WR, REG_RD, input wire [7:0] REG_ADDR,
  REG_WDATA, REG_RDATA, input wire [2:0] TEST_CURRENT, input wire SAMPLE_REQ,
  input wire [1:0] SAMPLE_SEL, input wire MEAS_ACTIVE, SAMPLE_DONE,
  input wire [7:0] SAMPLE_DATA);
  wire cfg_w = REG_WR && REG_ADDR == 8'h0E;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  start_sets_a: assert property (cfg_w && REG_WDATA[7:6] == 2'b10 && !MEAS_ACTIVE
    |=> MEAS_ACTIVE) else $error("start lost");
  abort_clears_a: assert property (cfg_w && REG_WDATA[6]
    |=> !MEAS_ACTIVE && TEST_CURRENT == 3'h0) else $error("abort ignored");
  idle_current_a: assert property (!MEAS_ACTIVE |-> TEST_CURRENT == 3'h0)
    else $error("current while idle");
  no_reserved_a: assert property (TEST_CURRENT != 3'h7)
    else $error("reserved current");
  req_pulse_a: assert property (SAMPLE_REQ |=> !SAMPLE_REQ)
    else $error("long request");
  req_in_run_a: assert property (SAMPLE_REQ |-> MEAS_ACTIVE)
    else $error("request outside run");
  first_delay_a: assert property ($rose(MEAS_ACTIVE) |-> !SAMPLE_REQ [*8])
    else $error("sample before delay");
  abort_reads0_a: assert property (REG_RD && REG_ADDR == 8'h0E |=> !REG_RDATA[6])
    else $error("abort bit sticky");
endmodule
bind battery_impedance_measurement bim_sva i_bim_sva (.*);

// File: battery_impedance_measurement_tb_top.sv
// Self-checking bench for the impedance sequencer
`timescale 1ns/1ps
module battery_impedance_measurement_tb_top;
  `define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
  reg CLK = 0, SRST = 1, REG_WR = 0, REG_RD = 0, SAMPLE_DONE = 0;
  reg [7:0] REG_ADDR = 0, REG_WDATA = 0, SAMPLE_DATA = 0;
  wire [7:0] REG_RDATA;
  wire [2:0] TEST_CURRENT;
  wire [1:0] SAMPLE_SEL;
  wire SAMPLE_REQ, MEAS_ACTIVE;
  int err_total = 0, tests_run = 0, n, s;
  reg [31:0] rows [6] = '{32'h15A0_A1A2, 32'h0000_0000, 32'h2AA0_A1A2, 32'h11A0_00A2,
    32'h24A0_A100, 32'h3F00_0000};
  battery_impedance_measurement #(.SHORT_CYCLES(20), .LONG_CYCLES(50))
    i_battery_impedance_measurement (.*);
  always #2.5 CLK = ~CLK;
  // Converter answers one cycle late; data toggles when idle
  always @(negedge CLK) begin
    SAMPLE_DONE <= SAMPLE_REQ;
    SAMPLE_DATA <= SAMPLE_REQ ? 8'hA0 + SAMPLE_SEL : ~SAMPLE_DATA;
  end
  function int dly(input [1:0] c);
    return c == 2'h1 ? 20 : c == 2'h2 ? 50 : 0;
  endfunction
  task wr(input [7:0] a, d);
    @(negedge CLK) REG_WR = 1; REG_ADDR = a; REG_WDATA = d;
    @(negedge CLK) REG_WR = 0;
  endtask
  task rd(input [7:0] a, e);
    @(negedge CLK) REG_RD = 1; REG_ADDR = a;
    @(negedge CLK) REG_RD = 0;
    `CHK("rdata", e, REG_RDATA)
  endtask
  task run_wait;
    n = 0;
    while (MEAS_ACTIVE !== 1'b0 && n < 500) begin
      @(negedge CLK) n++;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000 err_total++;
    print_verdict;
  end
  initial begin
    repeat (5) @(negedge CLK);
    SRST = 0;
    rd(8'h0D, 8'h00);
    rd(8'h20, 8'h00);
    foreach (rows[i]) begin
      s = dly(rows[i][29:28]) + dly(rows[i][27:26]) + dly(rows[i][25:24]);
      wr(8'h0D, rows[i][31:24]);
      wr(8'h0E, 8'h81);
      run_wait;
      `CHK("span", 1'b1, n >= s && n < s + 24)
      rd(8'h0F, rows[i][23:16]);
      rd(8'h10, rows[i][15:8]);
      rd(8'h11, rows[i][7:0]);
    end
    rd(8'h0E, 8'h01);
    wr(8'h0D, 8'h20);
    wr(8'h0E, 8'h81);
    repeat (10) @(negedge CLK);
    wr(8'h0E, 8'h83);
    @(negedge CLK) `CHK("cur", 3'h3, TEST_CURRENT)
    run_wait;
    `CHK("restart", 1'b1, n < 48)
    wr(8'h0E, 8'h80);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0E, c[7:0]);
      @(negedge CLK) `CHK("cur", c == 7 ? 3'h0 : c[2:0], TEST_CURRENT)
    end
    wr(8'h0E, 8'h05);
    @(negedge CLK) `CHK("cur", 3'h5, TEST_CURRENT)
    wr(8'h0E, 8'h40);
    `CHK("abort", 4'h0, {MEAS_ACTIVE, TEST_CURRENT})
    wr(8'h0E, 8'hC1);
    `CHK("abort", 1'b0, MEAS_ACTIVE)
    wr(8'h0E, 8'h82);
    repeat (3) @(negedge CLK);
    SRST = 1;
    @(negedge CLK) SRST = 0;
    `CHK("reset", 4'h0, {MEAS_ACTIVE, TEST_CURRENT})
    rd(8'h0F, 8'h00);
    print_verdict;
  end
endmodule
